// File: design/lineif_pkg.sv
// Constants, codes and types for the control-mode decode and signal-loss
// detection of the quad line interface.
// Assumes every strap and pin input is already synchronous to clk.
//
// Operation
// - Flag loss on long zero run or density
// - Flag clears itself once density recovers
// - Tri-level strap picks hardware, serial, parallel
// - Two straps pick one of four parallel styles
// - Mux strap: separate or shared address/data bus
// - Hardware mode takes config from config pins
// - Serial mode uses five serial pins only
// - Parallel mode uses parallel bus pin group
// - Host-type strap picks strobe convention
package lineif_pkg;

    localparam int CHANNELS    = 4;
    // Plain defaults: loss criteria are tuned per application
    localparam int ZERO_RUN    = 32;
    localparam int WINDOW_BITS = 32;
    localparam int MIN_ONES    = 4;

    // Tri-level strap as seen by the core: low, mid-supply, high
    localparam logic [1:0] TRI_LOW  = 2'h0;
    localparam logic [1:0] TRI_MID  = 2'h1;
    localparam logic [1:0] TRI_HIGH = 2'h2;

    typedef enum logic [5:0] {
        MODE_HW         = 6'h01,
        MODE_SERIAL     = 6'h02,
        MODE_PAR_SEP_DS = 6'h04,
        MODE_PAR_SEP_RW = 6'h08,
        MODE_PAR_MUX_DS = 6'h10,
        MODE_PAR_MUX_RW = 6'h20
    } ctrl_mode_t;

    localparam ctrl_mode_t MODE_RST   = MODE_HW;
    localparam logic [1:0] JA_RST     = TRI_MID;
    localparam logic       FLAG_RST   = 1'h1;

endpackage

// File: design/los_if.sv
// Per-channel link between the decode top and a signal-loss detector.
// Assumes bit_en marks one received bit time, one clk cycle wide.
`timescale 1ns/1ns
interface los_if;
    logic bit_en;
    logic bit_one;
    logic flag;
    modport det (input bit_en, input bit_one, output flag);
    modport top (output bit_en, output bit_one, input flag);
endinterface

// File: design/signal_loss_det.sv
// One channel of signal-loss detection on the recovered bit stream.
// Assumes one received bit per bit_en pulse; clk far faster than bits.
`timescale 1ns/1ns
module signal_loss_det #(
    parameter int ZERO_RUN    = lineif_pkg::ZERO_RUN,
    parameter int WINDOW_BITS = lineif_pkg::WINDOW_BITS,
    parameter int MIN_ONES    = lineif_pkg::MIN_ONES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Bit stream and flag
    los_if.det        lnk
);
    import lineif_pkg::*;

    localparam int RW = $clog2(ZERO_RUN + 1);
    localparam int WW = $clog2(WINDOW_BITS + 1);

    if (ZERO_RUN < 2 || WINDOW_BITS < 2 || MIN_ONES < 1 ||
        MIN_ONES > WINDOW_BITS) begin : g_bad_criteria
        $error("signal_loss_det: unusable loss criteria");
    end

    localparam logic [RW-1:0] RUN_MAX  = RW'(ZERO_RUN);
    localparam logic [WW-1:0] WIN_LAST = WW'(WINDOW_BITS - 1);
    localparam logic [WW-1:0] ONES_MIN = WW'(MIN_ONES);

    logic [RW-1:0] run_ff,  nxt_run;
    logic [WW-1:0] win_ff,  nxt_win;
    logic [WW-1:0] ones_ff, nxt_ones;
    logic          flag_ff, nxt_flag;
    logic          win_end;
    logic [WW-1:0] ones_now;

    always_comb begin
        nxt_run  = run_ff;
        nxt_win  = win_ff;
        nxt_ones = ones_ff;
        nxt_flag = flag_ff;
        win_end  = lnk.bit_en && (win_ff == WIN_LAST);
        ones_now = ones_ff + WW'(lnk.bit_one);
        if (lnk.bit_en) begin
            if (lnk.bit_one) begin
                nxt_run = '0;
            end else if (run_ff != RUN_MAX) begin
                nxt_run = run_ff + RW'(1);
            end
            nxt_win  = win_end ? '0 : win_ff + WW'(1);
            nxt_ones = win_end ? '0 : ones_now;
            // Recovery is judged only on whole windows
            if (win_end && ones_now >= ONES_MIN &&
                run_ff != RUN_MAX) begin
                nxt_flag = 1'b0;
            end
            // Setting wins over a recovery in the same bit
            if (win_end && ones_now < ONES_MIN) begin
                nxt_flag = 1'b1;
            end
            if (!lnk.bit_one && run_ff >= RUN_MAX - RW'(1)) begin
                nxt_flag = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            run_ff  <= '0;
            win_ff  <= '0;
            ones_ff <= '0;
            flag_ff <= FLAG_RST;
        end else begin
            run_ff  <= nxt_run;
            win_ff  <= nxt_win;
            ones_ff <= nxt_ones;
            flag_ff <= nxt_flag;
        end
    end

    assign lnk.flag = flag_ff;

    zero_run_set_a: assert property (
        @(posedge clk) disable iff (rst)
        lnk.bit_en && !lnk.bit_one && run_ff == RUN_MAX - RW'(1)
        |=> lnk.flag && run_ff == RUN_MAX)
        else $error("flag not set after long zero run");

    density_set_a: assert property (
        @(posedge clk) disable iff (rst)
        win_end && ones_now < ONES_MIN |=> lnk.flag && win_ff == '0)
        else $error("flag not set on low ones density");

    clear_at_window_a: assert property (
        @(posedge clk) disable iff (rst)
        $fell(lnk.flag) |-> $past(win_end) && $past(ones_now) >= ONES_MIN)
        else $error("flag cleared outside a good window");

    self_clear_a: assert property (
        @(posedge clk) disable iff (rst)
        lnk.flag && win_end && ones_now >= ONES_MIN && run_ff == '0 &&
        lnk.bit_one |=> !lnk.flag)
        else $error("flag did not clear on recovered signal");

    flag_recover_c: cover property (@(posedge clk) disable iff (rst)
        $fell(lnk.flag));
    flag_loss_c: cover property (@(posedge clk) disable iff (rst)
        $rose(lnk.flag));

endmodule

// File: design/ctrl_mode_decode.sv
// Control-mode strap decode, pin-function routing and per-channel
// signal-loss outputs of the quad line interface.
// Assumes straps are static and all inputs synchronous to clk.
`timescale 1ns/1ns
module ctrl_mode_decode #(
    parameter int CHANNELS    = lineif_pkg::CHANNELS,
    parameter int ZERO_RUN    = lineif_pkg::ZERO_RUN,
    parameter int WINDOW_BITS = lineif_pkg::WINDOW_BITS,
    parameter int MIN_ONES    = lineif_pkg::MIN_ONES
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Mode straps
    input  wire logic [1:0]             ctrl_iface_select,
    input  wire logic                   bus_mux_select,
    input  wire logic                   host_type_select,
    // Hardware configuration pins
    input  wire logic [3:0]             loopback_pins,
    input  wire logic                   line_code_select,
    input  wire logic                   recv_edge_polarity,
    input  wire logic [1:0]             jitter_atten_place,
    input  wire logic                   driver_oe,
    // Received bit streams
    input  wire logic [CHANNELS-1:0]    rx_bit_en,
    input  wire logic [CHANNELS-1:0]    rx_bit_one,
    // Decoded mode
    output lineif_pkg::ctrl_mode_t      ctrl_mode,
    output logic                        strap_fault,
    output logic                        serial_port_en,
    output logic                        par_port_en,
    output logic                        par_mux_bus,
    output logic                        par_rw_strobes,
    // Hardware-mode configuration
    output logic [3:0]                  cfg_loopback,
    output logic                        cfg_ami_code,
    output logic                        cfg_recv_edge,
    output logic [1:0]                  cfg_ja_place,
    output logic                        cfg_driver_oe,
    // Signal-loss outputs
    output logic [CHANNELS-1:0]         signal_absent_flag
);
    import lineif_pkg::*;

    if (CHANNELS < 1 || CHANNELS > 4) begin : g_bad_channels
        $error("ctrl_mode_decode: CHANNELS must be 1 to 4");
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Straps are sampled once after reset release so that a glitch on a
    // pulled-mid strap cannot move the pin functions mid-operation.
    ctrl_mode_t  mode_ff,    nxt_mode;
    logic        taken_ff,   nxt_taken;
    logic        fault_ff,   nxt_fault;
    ctrl_mode_t  strap_mode;
    logic        strap_bad;

    always_comb begin
        strap_mode = MODE_HW;
        unique case (ctrl_iface_select)
            TRI_LOW:  strap_mode = MODE_HW;
            TRI_MID:  strap_mode = MODE_SERIAL;
            TRI_HIGH: begin
                unique case ({bus_mux_select, host_type_select})
                    2'h0: strap_mode = MODE_PAR_SEP_DS;
                    2'h1: strap_mode = MODE_PAR_SEP_RW;
                    2'h2: strap_mode = MODE_PAR_MUX_DS;
                    2'h3: strap_mode = MODE_PAR_MUX_RW;
                endcase
            end
            // Undefined strap level falls back to pin control
            default:  strap_mode = MODE_HW;
        endcase
        // The board must ground the mux strap outside parallel mode
        strap_bad = bus_mux_select &&
                    ctrl_iface_select != TRI_HIGH;
        nxt_mode  = mode_ff;
        nxt_fault = fault_ff;
        nxt_taken = 1'b1;
        if (!taken_ff) begin
            nxt_mode  = strap_mode;
            nxt_fault = strap_bad;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_ff  <= MODE_RST;
            taken_ff <= 1'b0;
            fault_ff <= 1'b0;
        end else begin
            mode_ff  <= nxt_mode;
            taken_ff <= nxt_taken;
            fault_ff <= nxt_fault;
        end
    end

    // Pin-function enables follow the latched mode
    logic is_hw;
    logic is_par;
    assign is_hw          = mode_ff == MODE_HW;
    assign is_par         = mode_ff inside {MODE_PAR_SEP_DS, MODE_PAR_SEP_RW,
                                            MODE_PAR_MUX_DS, MODE_PAR_MUX_RW};
    assign ctrl_mode      = mode_ff;
    assign strap_fault    = fault_ff;
    assign serial_port_en = taken_ff && mode_ff == MODE_SERIAL;
    assign par_port_en    = taken_ff && is_par;
    assign par_mux_bus    = taken_ff && mode_ff inside {MODE_PAR_MUX_DS,
                                                        MODE_PAR_MUX_RW};
    assign par_rw_strobes = taken_ff && mode_ff inside {MODE_PAR_SEP_RW,
                                                        MODE_PAR_MUX_RW};

    // Configuration pins are live only under pin control; host modes
    // leave them at neutral values for the register file to override.
    logic [3:0] lp_ff,   nxt_lp;
    logic       ami_ff,  nxt_ami;
    logic       edge_ff, nxt_edge;
    logic [1:0] ja_ff,   nxt_ja;
    logic       oe_ff,   nxt_oe;

    always_comb begin
        nxt_lp   = 4'h0;
        nxt_ami  = 1'b0;
        nxt_edge = 1'b0;
        nxt_ja   = JA_RST;
        nxt_oe   = 1'b0;
        if (taken_ff && is_hw) begin
            nxt_lp   = loopback_pins;
            nxt_ami  = line_code_select;
            nxt_edge = recv_edge_polarity;
            nxt_ja   = (jitter_atten_place == 2'h3) ? JA_RST
                                                    : jitter_atten_place;
            nxt_oe   = driver_oe;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lp_ff   <= 4'h0;
            ami_ff  <= 1'b0;
            edge_ff <= 1'b0;
            ja_ff   <= JA_RST;
            oe_ff   <= 1'b0;
        end else begin
            lp_ff   <= nxt_lp;
            ami_ff  <= nxt_ami;
            edge_ff <= nxt_edge;
            ja_ff   <= nxt_ja;
            oe_ff   <= nxt_oe;
        end
    end

    assign cfg_loopback  = lp_ff;
    assign cfg_ami_code  = ami_ff;
    assign cfg_recv_edge = edge_ff;
    assign cfg_ja_place  = ja_ff;
    assign cfg_driver_oe = oe_ff;

    // One detector per channel, no shared state between them
    los_if lif[CHANNELS] ();

    for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
        assign lif[g].bit_en  = rx_bit_en[g];
        assign lif[g].bit_one = rx_bit_one[g];
        assign signal_absent_flag[g] = lif[g].flag;
        signal_loss_det #(
            .ZERO_RUN    (ZERO_RUN),
            .WINDOW_BITS (WINDOW_BITS),
            .MIN_ONES    (MIN_ONES)
        ) u_det (
            .clk (clk),
            .rst (rst),
            .lnk (lif[g])
        );
    end

    mode_static_a: assert property (
        taken_ff |=> $stable(ctrl_mode))
        else $error("mode changed after strap capture");

    decode_tri_a: assert property (
        !taken_ff ##1 taken_ff |->
        ($past(ctrl_iface_select) == TRI_LOW  -> ctrl_mode == MODE_HW) &&
        ($past(ctrl_iface_select) == TRI_MID  -> ctrl_mode == MODE_SERIAL) &&
        ($past(ctrl_iface_select) == TRI_HIGH -> par_port_en))
        else $error("interface strap decoded wrongly");

    decode_par_a: assert property (
        !taken_ff && ctrl_iface_select == TRI_HIGH |=>
        par_mux_bus == $past(bus_mux_select) &&
        par_rw_strobes == $past(host_type_select))
        else $error("parallel variant decoded wrongly");

    ports_exclusive_a: assert property (
        !(serial_port_en && par_port_en) &&
        (serial_port_en -> !is_hw) && (par_mux_bus -> par_port_en))
        else $error("pin groups enabled together");

    hw_config_a: assert property (
        taken_ff && is_hw |=> cfg_loopback == $past(loopback_pins) &&
        cfg_driver_oe == $past(driver_oe))
        else $error("hardware config pins not followed");

    host_config_a: assert property (
        taken_ff && !is_hw |=> cfg_loopback == 4'h0 && !cfg_driver_oe)
        else $error("config pins leak into host mode");

    hw_mode_c:     cover property (taken_ff && is_hw);
    serial_mode_c: cover property (serial_port_en);
    mux_rw_c:      cover property (par_mux_bus && par_rw_strobes);

endmodule

// File: tb/board_side.sv
// Far side of the decode block: board strap wiring and a line source.
// Assumes the bench asks for straps and bits just after a falling edge.
`timescale 1ns/1ns
module board_side #(
    parameter int CHANNELS = 4
) (
    // Clock
    input  wire logic                clk,
    // Requests from the bench
    input  wire logic [1:0]          want_iface,
    input  wire logic                want_mux,
    input  wire logic                want_host,
    input  wire logic                misstrap,
    input  wire logic                send,
    input  wire logic [CHANNELS-1:0] bits,
    // Pins toward the device
    output logic [1:0]               ctrl_iface_select,
    output logic                     bus_mux_select,
    output logic                     host_type_select,
    output logic [CHANNELS-1:0]      rx_bit_en,
    output logic [CHANNELS-1:0]      rx_bit_one
);
    logic [CHANNELS-1:0] junk_ff = '0;

    always_comb begin
        ctrl_iface_select = want_iface;
        host_type_select  = want_host;
        // Grounded outside parallel mode unless a miswired board is wanted
        bus_mux_select = want_mux &
                         ((want_iface == 2'h2) | misstrap);
        rx_bit_en  = {CHANNELS{send}};
        rx_bit_one = send ? bits : junk_ff;
    end

    // Data wanders between bits so a stale value never passes for data
    always @(posedge clk) begin
        junk_ff <= ~junk_ff;
    end
endmodule

// File: tb/ctrl_mode_decode_tb.sv
// Self-checking bench for the mode decode and the signal-loss flags.
// Assumes board_side as far side; loss counts shrunk to 4, 8 and 2.
`timescale 1ns/1ns
module ctrl_mode_decode_tb;
    import lineif_pkg::*;

    logic                clk        = 1'b0;
    logic                rst        = 1'b1;
    logic [1:0]          want_iface = 2'h0;
    logic                want_mux   = 1'b0;
    logic                want_host  = 1'b0;
    logic                misstrap   = 1'b0;
    logic                send       = 1'b0;
    logic [CHANNELS-1:0] bits       = '0;
    logic [3:0]          lp         = 4'h0;
    logic                code_sel   = 1'b0;
    logic                edge_sel   = 1'b0;
    logic [1:0]          ja_sel     = 2'h0;
    logic                oe_sel     = 1'b0;
    logic [31:0]         lfsr       = 32'h3A6C25EA;
    logic [23:0]         exp_q[$];
    event                chk_ev;
    int                  failures   = 0;
    int                  checked    = 0;
    logic [1:0]          ifc;
    logic                mx;
    logic                ht;
    logic [1:0]          iface_pin;
    logic                mux_pin;
    logic                host_pin;
    logic [CHANNELS-1:0] bit_en;
    logic [CHANNELS-1:0] bit_one;
    ctrl_mode_t          ctrl_mode;
    logic                strap_fault;
    logic                ser_en;
    logic                par_en;
    logic                par_mux;
    logic                par_rw;
    logic [3:0]          cfg_lp;
    logic                cfg_ami;
    logic                cfg_edge;
    logic [1:0]          cfg_ja;
    logic                cfg_oe;
    logic [CHANNELS-1:0] flags;
    wire  logic [23:0]   obs = {ctrl_mode, strap_fault, ser_en, par_en,
                                par_mux, par_rw, cfg_lp, cfg_ami, cfg_edge,
                                cfg_ja, cfg_oe, flags};

    initial begin
        forever #20 clk = ~clk;
    end

    board_side #(.CHANNELS(CHANNELS)) far_u (
        .clk(clk), .want_iface(want_iface), .want_mux(want_mux),
        .want_host(want_host), .misstrap(misstrap), .send(send),
        .bits(bits), .ctrl_iface_select(iface_pin),
        .bus_mux_select(mux_pin), .host_type_select(host_pin),
        .rx_bit_en(bit_en), .rx_bit_one(bit_one));

    ctrl_mode_decode #(.CHANNELS(CHANNELS), .ZERO_RUN(4), .WINDOW_BITS(8),
                       .MIN_ONES(2)) dut_u (
        .clk(clk), .rst(rst), .ctrl_iface_select(iface_pin),
        .bus_mux_select(mux_pin), .host_type_select(host_pin),
        .loopback_pins(lp), .line_code_select(code_sel),
        .recv_edge_polarity(edge_sel), .jitter_atten_place(ja_sel),
        .driver_oe(oe_sel), .rx_bit_en(bit_en), .rx_bit_one(bit_one),
        .ctrl_mode(ctrl_mode), .strap_fault(strap_fault),
        .serial_port_en(ser_en), .par_port_en(par_en),
        .par_mux_bus(par_mux), .par_rw_strobes(par_rw),
        .cfg_loopback(cfg_lp), .cfg_ami_code(cfg_ami),
        .cfg_recv_edge(cfg_edge), .cfg_ja_place(cfg_ja),
        .cfg_driver_oe(cfg_oe), .signal_absent_flag(flags));

    function automatic logic [23:0] expect_all(input logic [1:0] i,
            input logic m, input logic h, input logic [3:0] f);
        logic [5:0] md;
        logic [8:0] cfg;
        logic       par;
        par = (i == 2'h2);
        md  = (i == 2'h1) ? 6'h02 : 6'h01;
        if (par) begin
            md = 6'h04 << {m, h};
        end
        cfg = {4'h0, 1'b0, 1'b0, 2'h1, 1'b0};
        if (md == 6'h01) begin
            cfg = {lp, code_sel, edge_sel,
                   (ja_sel == 2'h3) ? 2'h1 : ja_sel, oe_sel};
        end
        return {md, m & ~par, md == 6'h02, par, par & m, par & h, cfg, f};
    endfunction

    task automatic note(input logic [23:0] e);
        exp_q.push_back(e);
        ->chk_ev;
    endtask

    always @(chk_ev) begin
        logic [23:0] e;
        e = exp_q.pop_front();
        checked++;
        if (obs !== e) begin
            failures++;
            $display("[FAIL] t=%0t got %h expected %h", $time, obs, e);
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic rnd_pins();
        lfsr = lfsr_next(lfsr);
        {lp, code_sel, edge_sel, ja_sel, oe_sel} = lfsr[8:0];
    endtask

    // Bits go out first-bit-high; gaps are random, else back to back
    task automatic send_bits(input logic [31:0] p, input int lo,
                             input int hi, input logic gaps);
        for (int j = lo; j < hi; j++) begin
            send = 1'b1;
            for (int c = 0; c < CHANNELS; c++) begin
                bits[c] = p[c*8 + 7 - j];
            end
            @(negedge clk);
            if (gaps) begin
                send = 1'b0;
                rnd_pins();
                repeat (1 + lfsr[1:0]) @(negedge clk);
            end
        end
        send = 1'b0;
        @(negedge clk);
    endtask

    task automatic end_sim();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        end_sim();
    end

    initial begin
        repeat (20) @(negedge clk);
        for (int k = 0; k < 16; k++) begin
            rst = 1'b1;
            repeat (2) @(negedge clk);
            {want_iface, want_mux, want_host} = k[3:0];
            misstrap = ~k[3];
            rnd_pins();
            rst = 1'b0;
            #1;
            ifc = want_iface;
            mx  = mux_pin;
            ht  = want_host;
            repeat (3) @(negedge clk);
            note(expect_all(ifc, mx, ht, 4'hF));
            // Straps move after capture; config pins keep being followed in hardware mode
            {want_iface, want_mux, want_host} = ~k[3:0];
            rnd_pins();
            repeat (2) @(negedge clk);
            note(expect_all(ifc, mx, ht, 4'hF));
        end
        rst = 1'b1;
        repeat (2) @(negedge clk);
        {want_iface, want_mux, want_host} = 4'h0;
        rst = 1'b0;
        send_bits({8'h30, 8'h11, 8'h00, 8'h55}, 0, 8, 1'b1);
        note(expect_all(2'h0, 1'b0, 1'b0, 4'hA));
        send_bits({8'hFF, 8'hFF, 8'hAA, 8'h00}, 0, 4, 1'b0);
        note(expect_all(2'h0, 1'b0, 1'b0, 4'hB));
        send_bits({8'hFF, 8'hFF, 8'hAA, 8'h00}, 4, 8, 1'b0);
        note(expect_all(2'h0, 1'b0, 1'b0, 4'h1));
        @(negedge clk);
        end_sim();
    end
endmodule
